//--- common/rdsc_regs.vh
// Register map, field positions, reset values and codes of the deviation and state config block
`ifndef RDSC_REGS_VH
`define RDSC_REGS_VH

// Register addresses on the serial register port
`define RDSC_ADDR_FREQ_DEV      6'h15
`define RDSC_ADDR_RX_TERM       6'h16
`define RDSC_ADDR_PKT_END       6'h17

// Reset values
`define RDSC_RST_FREQ_DEV       8'h47
`define RDSC_RST_RX_TERM        8'h07
`define RDSC_RST_PKT_END        8'h30

// Writable bit masks, unused bits read zero
`define RDSC_MASK_FREQ_DEV      8'h77
`define RDSC_MASK_RX_TERM       8'h1F
`define RDSC_MASK_PKT_END       8'h3F

// Field positions
`define RDSC_DEV_E_HI           6
`define RDSC_DEV_E_LO           4
`define RDSC_DEV_M_HI           2
`define RDSC_DEV_M_LO           0
`define RDSC_CS_TERM_BIT        4
`define RDSC_CCA_HI             5
`define RDSC_CCA_LO             4
`define RDSC_RXOFF_HI           3
`define RDSC_RXOFF_LO           2
`define RDSC_TXOFF_HI           1
`define RDSC_TXOFF_LO           0

// Modulation codes
`define RDSC_MOD_2FSK           2'h0
`define RDSC_MOD_GFSK           2'h1
`define RDSC_MOD_OOK            2'h2
`define RDSC_MOD_4FSK           2'h3

// Radio states
`define RDSC_ST_IDLE            2'h0
`define RDSC_ST_FSTX            2'h1
`define RDSC_ST_TX              2'h2
`define RDSC_ST_RX              2'h3

// Clear channel selector codes
`define RDSC_CCA_ALWAYS         2'h0
`define RDSC_CCA_RSSI           2'h1
`define RDSC_CCA_NOPKT          2'h2
`define RDSC_CCA_BOTH           2'h3

// OOK carrier sense window in symbols, minus one for the counter compare
`define RDSC_OOK_CS_SYMBOLS     4'h8
`define RDSC_OOK_CS_LAST        4'h7

// Deviation word scale: one unit equals crystal frequency over two to the 17
`define RDSC_DEV_SCALE_LOG2     17

// Serial frame bit counts
`define RDSC_HDR_LAST_BIT       4'h7
`define RDSC_DATA_LAST_BIT      4'hF
`define RDSC_DATA_FIRST_BIT     4'h8

`endif

//--- rtl/rdsc_dev_calc.v
// Frequency deviation word and signed carrier offset for FSK-family transmit
`timescale 1ns/100ps
`default_nettype none
`include "rdsc_regs.vh"

module rdsc_dev_calc
(
  input  wire        clk,
  input  wire        rstn,
  input  wire [2:0]  devExp,
  input  wire [2:0]  devMant,
  input  wire        ookMode,
  input  wire        txActive,
  input  wire        txSymbol,
  output reg  [10:0] devWord,
  output reg  [11:0] freqOffset
);

  // Mantissa with implicit leading one, shifted by the exponent
  function [10:0] devCalc;
    input [2:0] e;
    input [2:0] m;
    begin
      devCalc = {7'h00, 1'b1, m} << e;
    end
  endfunction

  wire [10:0] devNow = devCalc(devExp, devMant);

  // Registered deviation and offset; OOK ignores the fields
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      devWord    <= 11'h000;
      freqOffset <= 12'h000;
    end
    else
    begin
      devWord <= ookMode ? 11'h000 : devNow;
      if (!txActive || ookMode)
        freqOffset <= 12'h000;
      else if (txSymbol)
        freqOffset <= {1'b0, devNow};
      else
        freqOffset <= 12'h000 - {1'b0, devNow};
    end
  end

endmodule // rdsc_dev_calc

`default_nettype wire

//--- rtl/rdsc_rx_term.v
// Carrier-sense based early termination of receive mode
`timescale 1ns/100ps
`default_nettype none
`include "rdsc_regs.vh"

module rdsc_rx_term
(
  input  wire clk,
  input  wire rstn,
  input  wire rxRestart,
  input  wire rxActive,
  input  wire ookMode,
  input  wire symTick,
  input  wire carrierSense,
  input  wire pktActive,
  output reg  rxTerminate
);

  reg [3:0] symCnt_r;
  reg       csSeen_r;
  reg       armed_r;

  // Symbol window counter and carrier-sense loss detection
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      symCnt_r    <= 4'h0;
      csSeen_r    <= 1'b0;
      armed_r     <= 1'b0;
      rxTerminate <= 1'b0;
    end
    else if (rxRestart)
    begin
      symCnt_r    <= 4'h0;
      csSeen_r    <= 1'b0;
      armed_r     <= 1'b1;
      rxTerminate <= 1'b0;
    end
    else if (!rxActive)
    begin
      armed_r     <= 1'b0;
      rxTerminate <= 1'b0;
    end
    else
    begin
      rxTerminate <= 1'b0;
      if (carrierSense)
        csSeen_r <= 1'b1;
      // OOK: give up after the symbol window without carrier sense
      if (ookMode && armed_r && !csSeen_r && !carrierSense && symTick)
      begin
        symCnt_r <= symCnt_r + 4'h1;
        if (symCnt_r == `RDSC_OOK_CS_LAST)
        begin
          rxTerminate <= 1'b1;
          armed_r     <= 1'b0;
        end
      end
      // FSK family: stop once carrier sense is lost outside a packet
      if (!ookMode && armed_r && csSeen_r && !carrierSense && !pktActive)
      begin
        rxTerminate <= 1'b1;
        armed_r     <= 1'b0;
      end
    end
  end

endmodule // rdsc_rx_term

`default_nettype wire

//--- rtl/rdsc_top.v
// Deviation and radio state configuration block with its serial register port
`timescale 1ns/100ps
`default_nettype none
`include "rdsc_regs.vh"

module rdsc_top
(
  input  wire        clk,
  input  wire        rstn,
  input  wire        spiCsn,
  input  wire        spiSclk,
  input  wire        spiMosi,
  output reg         spiMiso,
  output reg         spiMisoOe,
  input  wire [1:0]  modSelect,
  input  wire        cmdIdle,
  input  wire        cmdRx,
  input  wire        cmdTx,
  input  wire        cmdFstx,
  input  wire        pktRxDone,
  input  wire        pktTxDone,
  input  wire        pktActive,
  input  wire        rssiBelowThr,
  input  wire        carrierSense,
  input  wire        symTick,
  input  wire        txSymbol,
  output reg  [1:0]  radioState,
  output wire [11:0] freqOffset,
  output wire [10:0] devWord,
  output reg         clearChannel,
  output reg         txPreambleStart,
  output wire        rxTerminate
);

  // Configuration registers
  reg  [7:0] freqDevReg_r;
  reg  [7:0] rxTermReg_r;
  reg  [7:0] pktEndReg_r;

  // Serial pin synchronisers
  reg        csnS1_r;
  reg        csnS2_r;
  reg        sclkS1_r;
  reg        sclkS2_r;
  reg        sclkS3_r;
  reg        mosiS1_r;
  reg        mosiS2_r;

  // Serial frame state
  reg  [3:0] bitCnt_r;
  reg  [7:0] shiftIn_r;
  reg  [7:0] shiftOut_r;
  reg  [5:0] addr_r;
  reg        rdMode_r;

  // Radio state machine
  reg  [1:0] radioState_nxt;
  reg        rxRestart_r;
  reg        preamble_nxt;

  // Read mux; unmapped addresses and unused bits give zero
  function [7:0] regRead;
    input [5:0] a;
    input [7:0] devR;
    input [7:0] termR;
    input [7:0] endR;
    begin
      case (a)
        `RDSC_ADDR_FREQ_DEV: regRead = devR & `RDSC_MASK_FREQ_DEV;
        `RDSC_ADDR_RX_TERM:  regRead = termR & `RDSC_MASK_RX_TERM;
        `RDSC_ADDR_PKT_END:  regRead = endR & `RDSC_MASK_PKT_END;
        default:             regRead = 8'h00;
      endcase
    end
  endfunction

  // Field views
  wire [2:0] devExp    = freqDevReg_r[`RDSC_DEV_E_HI:`RDSC_DEV_E_LO];
  wire [2:0] devMant   = freqDevReg_r[`RDSC_DEV_M_HI:`RDSC_DEV_M_LO];
  wire       csTermEn  = rxTermReg_r[`RDSC_CS_TERM_BIT];
  wire [1:0] ccaSel    = pktEndReg_r[`RDSC_CCA_HI:`RDSC_CCA_LO];
  wire [1:0] rxOffMode = pktEndReg_r[`RDSC_RXOFF_HI:`RDSC_RXOFF_LO];
  wire [1:0] txOffMode = pktEndReg_r[`RDSC_TXOFF_HI:`RDSC_TXOFF_LO];
  wire       ookMode   = (modSelect == `RDSC_MOD_OOK);

  // Serial port edges and strobes
  wire       spiActive = ~csnS2_r;
  wire       sclkRise  = sclkS2_r & ~sclkS3_r;
  wire       sclkFall  = ~sclkS2_r & sclkS3_r;
  wire [7:0] rxByte    = {shiftIn_r[6:0], mosiS2_r};
  wire [5:0] hdrAddr   = {shiftIn_r[4:0], mosiS2_r};
  wire       dataEnd   = spiActive & sclkRise & (bitCnt_r == `RDSC_DATA_LAST_BIT);
  wire       wrStb     = dataEnd & ~rdMode_r;
  wire [5:0] addrInc   = addr_r + 6'h01;

  // Two-stage synchronisers on the serial pins
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      csnS1_r  <= 1'b1;
      csnS2_r  <= 1'b1;
      sclkS1_r <= 1'b0;
      sclkS2_r <= 1'b0;
      sclkS3_r <= 1'b0;
      mosiS1_r <= 1'b0;
      mosiS2_r <= 1'b0;
    end
    else
    begin
      csnS1_r  <= spiCsn;
      csnS2_r  <= csnS1_r;
      sclkS1_r <= spiSclk;
      sclkS2_r <= sclkS1_r;
      sclkS3_r <= sclkS2_r;
      mosiS1_r <= spiMosi;
      mosiS2_r <= mosiS1_r;
    end
  end

  // Serial frame: header byte then data bytes, address steps in bursts
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bitCnt_r   <= 4'h0;
      shiftIn_r  <= 8'h00;
      shiftOut_r <= 8'h00;
      addr_r     <= 6'h00;
      rdMode_r   <= 1'b0;
      spiMiso    <= 1'b0;
      spiMisoOe  <= 1'b0;
    end
    else if (!spiActive)
    begin
      bitCnt_r  <= 4'h0;
      spiMiso   <= 1'b0;
      spiMisoOe <= 1'b0;
    end
    else
    begin
      spiMisoOe <= 1'b1;
      if (sclkRise)
      begin
        shiftIn_r <= rxByte;
        if (bitCnt_r == `RDSC_HDR_LAST_BIT)
        begin
          bitCnt_r   <= bitCnt_r + 4'h1;
          addr_r     <= hdrAddr;
          rdMode_r   <= shiftIn_r[6];
          shiftOut_r <= regRead(hdrAddr, freqDevReg_r, rxTermReg_r, pktEndReg_r);
        end
        else if (bitCnt_r == `RDSC_DATA_LAST_BIT)
        begin
          bitCnt_r   <= `RDSC_DATA_FIRST_BIT;
          addr_r     <= addrInc;
          shiftOut_r <= regRead(addrInc, freqDevReg_r, rxTermReg_r, pktEndReg_r);
        end
        else
          bitCnt_r <= bitCnt_r + 4'h1;
      end
      else if (sclkFall)
      begin
        if (bitCnt_r >= `RDSC_DATA_FIRST_BIT)
        begin
          spiMiso    <= shiftOut_r[7];
          shiftOut_r <= {shiftOut_r[6:0], 1'b0};
        end
        else
          spiMiso <= 1'b0;
      end
    end
  end

  // Register writes; unused bits are masked off
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      freqDevReg_r <= `RDSC_RST_FREQ_DEV;
      rxTermReg_r  <= `RDSC_RST_RX_TERM;
      pktEndReg_r  <= `RDSC_RST_PKT_END;
    end
    else if (wrStb)
    begin
      case (addr_r)
        `RDSC_ADDR_FREQ_DEV: freqDevReg_r <= rxByte & `RDSC_MASK_FREQ_DEV;
        `RDSC_ADDR_RX_TERM:  rxTermReg_r  <= rxByte & `RDSC_MASK_RX_TERM;
        `RDSC_ADDR_PKT_END:  pktEndReg_r  <= rxByte & `RDSC_MASK_PKT_END;
        default:             freqDevReg_r <= freqDevReg_r;
      endcase
    end
  end

  // Next radio state from commands and packet completion
  always @*
  begin
    radioState_nxt = radioState;
    preamble_nxt   = 1'b0;
    if (cmdIdle)
      radioState_nxt = `RDSC_ST_IDLE;
    else
    begin
      case (radioState)
        `RDSC_ST_IDLE:
        begin
          if (cmdRx)
            radioState_nxt = `RDSC_ST_RX;
          else if (cmdTx)
            radioState_nxt = `RDSC_ST_TX;
          else if (cmdFstx)
            radioState_nxt = `RDSC_ST_FSTX;
        end
        `RDSC_ST_FSTX:
        begin
          if (cmdTx)
            radioState_nxt = `RDSC_ST_TX;
          else if (cmdRx)
            radioState_nxt = `RDSC_ST_RX;
        end
        `RDSC_ST_RX:
        begin
          if (pktRxDone)
          begin
            case (rxOffMode)
              2'h0:    radioState_nxt = `RDSC_ST_IDLE;
              2'h1:    radioState_nxt = `RDSC_ST_FSTX;
              2'h2:    radioState_nxt = `RDSC_ST_TX;
              default: radioState_nxt = `RDSC_ST_RX;
            endcase
          end
          else if (rxTerminate)
            radioState_nxt = `RDSC_ST_IDLE;
          else if (cmdTx)
            radioState_nxt = `RDSC_ST_TX;
        end
        `RDSC_ST_TX:
        begin
          if (pktTxDone)
          begin
            case (txOffMode)
              2'h0:    radioState_nxt = `RDSC_ST_IDLE;
              2'h1:    radioState_nxt = `RDSC_ST_FSTX;
              2'h2:
              begin
                radioState_nxt = `RDSC_ST_TX;
                preamble_nxt   = 1'b1;
              end
              default: radioState_nxt = `RDSC_ST_RX;
            endcase
          end
          else if (cmdRx)
            radioState_nxt = `RDSC_ST_RX;
        end
        default: radioState_nxt = `RDSC_ST_IDLE;
      endcase
    end
  end

  // State register, receive restart and preamble strobe
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      radioState      <= `RDSC_ST_IDLE;
      rxRestart_r     <= 1'b0;
      txPreambleStart <= 1'b0;
    end
    else
    begin
      radioState      <= radioState_nxt;
      txPreambleStart <= preamble_nxt;
      rxRestart_r     <= (radioState_nxt == `RDSC_ST_RX) &&
                         ((radioState != `RDSC_ST_RX) || pktRxDone);
    end
  end

  // Clear channel indication from the selector
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      clearChannel <= 1'b0;
    else
    begin
      case (ccaSel)
        `RDSC_CCA_ALWAYS: clearChannel <= 1'b1;
        `RDSC_CCA_RSSI:   clearChannel <= rssiBelowThr;
        `RDSC_CCA_NOPKT:  clearChannel <= ~pktActive;
        default:          clearChannel <= rssiBelowThr & ~pktActive;
      endcase
    end
  end

  // Deviation arithmetic and transmit offset
  rdsc_dev_calc uDevCalc
  (
    .clk        (clk),
    .rstn       (rstn),
    .devExp     (devExp),
    .devMant    (devMant),
    .ookMode    (ookMode),
    .txActive   (radioState == `RDSC_ST_TX),
    .txSymbol   (txSymbol),
    .devWord    (devWord),
    .freqOffset (freqOffset)
  );

  // Receive termination on carrier sense
  rdsc_rx_term uRxTerm
  (
    .clk          (clk),
    .rstn         (rstn),
    .rxRestart    (rxRestart_r),
    .rxActive     (csTermEn && (radioState == `RDSC_ST_RX)),
    .ookMode      (ookMode),
    .symTick      (symTick),
    .carrierSense (carrierSense),
    .pktActive    (pktActive),
    .rxTerminate  (rxTerminate)
  );

endmodule // rdsc_top

`default_nettype wire

//--- tb/rdsc_checker.sv
// Port assertions for the deviation and radio state config block
`timescale 1ns/100ps
`default_nettype none
module rdsc_checker
(
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic [1:0]  modSelect,
  input wire logic        pktTxDone,
  input wire logic        pktActive,
  input wire logic        rssiBelowThr,
  input wire logic        symTick,
  input wire logic        txSymbol,
  input wire logic [1:0]  radioState,
  input wire logic [11:0] freqOffset,
  input wire logic [10:0] devWord,
  input wire logic        clearChannel,
  input wire logic        txPreambleStart,
  input wire logic        rxTerminate
);
  logic [3:0] symCnt_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // Symbol ticks since receive was entered, saturating
  always @(posedge clk or negedge rstn)
    if (!rstn)
      symCnt_r <= 4'h0;
    else if (radioState != 2'h3)
      symCnt_r <= 4'h0;
    else if (symTick && symCnt_r != 4'hF)
      symCnt_r <= symCnt_r + 4'h1;

  // Deviation word and carrier offset
  AST_DEV_OOK: assert property
    (modSelect == 2'h2 |=> devWord == 11'h000)
    else $error("deviation word not zero under OOK");
  AST_OFS_ZERO: assert property
    (radioState != 2'h2 || modSelect == 2'h2 |=> freqOffset == 12'h000)
    else $error("carrier offset outside FSK transmit");
  AST_OFS_SIGN: assert property
    (radioState == 2'h2 && modSelect != 2'h2 ##1 $stable(devWord)
      |-> freqOffset == ($past(txSymbol) ? {1'b0, devWord} : 12'h000 - {1'b0, devWord}))
    else $error("carrier offset sign or size wrong");
  // Clear channel and receive termination
  AST_CCA_CLEAR: assert property
    (rssiBelowThr && !pktActive |=> clearChannel)
    else $error("quiet channel not shown clear");
  AST_TERM_INRX: assert property
    (rxTerminate |-> $past(radioState) == 2'h3)
    else $error("termination outside receive");
  AST_TERM_PULSE: assert property
    (rxTerminate |=> !rxTerminate)
    else $error("termination longer than one cycle");
  AST_OOK_WIN: assert property
    (rxTerminate && modSelect == 2'h2 |-> symCnt_r >= 4'h8)
    else $error("OOK timeout before eight symbols");
  AST_PRE_PULSE: assert property
    (txPreambleStart |-> $past(pktTxDone) ##1 !txPreambleStart)
    else $error("preamble start without packet end");

  // Main scenarios reached
  cover property (rxTerminate);
  cover property (txPreambleStart);
  cover property (radioState == 2'h2 && freqOffset != 12'h000);
endmodule // rdsc_checker

bind rdsc_top rdsc_checker chk
(
  .clk(clk), .rstn(rstn), .modSelect(modSelect), .pktTxDone(pktTxDone),
  .pktActive(pktActive), .rssiBelowThr(rssiBelowThr), .symTick(symTick),
  .txSymbol(txSymbol), .radioState(radioState), .freqOffset(freqOffset),
  .devWord(devWord), .clearChannel(clearChannel), .txPreambleStart(txPreambleStart),
  .rxTerminate(rxTerminate)
);
`default_nettype wire

//--- tb/rdsc_host_model.sv
// Host controller model on the serial register port
`timescale 1ns/100ps
`default_nettype none
module rdsc_host_model
(
  input  wire logic clk,
  input  wire logic spiMiso,
  output logic      spiCsn,
  output logic      spiSclk,
  output logic      spiMosi
);
  localparam int HALF = 6; // Clocks per serial phase, well above the sync delay

  // Idle port levels
  initial
  begin
    spiCsn  = 1'b1;
    spiSclk = 1'b0;
    spiMosi = 1'b0;
  end

  // Header then one data byte, MSB first, data sampled before each rise
  task automatic xfer(input logic [7:0] hdr, input logic [7:0] din, output logic [7:0] q);
    logic [15:0] bits;
    bits = {hdr, din};
    q = 8'h00;
    spiCsn <= 1'b0;
    repeat (HALF) @(posedge clk);
    for (int i = 15; i >= 0; i--)
    begin
      spiMosi <= bits[i];
      repeat (HALF) @(posedge clk);
      q = {q[6:0], spiMiso};
      spiSclk <= 1'b1;
      repeat (HALF) @(posedge clk);
      spiSclk <= 1'b0;
    end
    repeat (HALF) @(posedge clk);
    spiCsn  <= 1'b1;
    spiMosi <= ~spiMosi; // Released line does not keep the last bit
    repeat (HALF) @(posedge clk);
  endtask
endmodule // rdsc_host_model
`default_nettype wire

//--- tb/radio_deviation_and_state_config_tb_top.sv
// Self-checking bench for the deviation and radio state config block
`timescale 1ns/100ps
`default_nettype none
`include "rdsc_regs.vh"
`define CHK(n, e, a) begin samplesChecked++; if ((a) !== (e)) begin errTotal++; \
  $display("FAIL %s expected %0h seen %0h", n, e, a); end end

module radio_deviation_and_state_config_tb_top;
  localparam logic [6:0] P_IDLE = 7'h40;
  localparam logic [6:0] P_RX   = 7'h20;
  localparam logic [6:0] P_TX   = 7'h10;
  localparam logic [6:0] P_FST  = 7'h08;
  localparam logic [6:0] P_RXD  = 7'h04;
  localparam logic [6:0] P_TXD  = 7'h02;
  localparam logic [6:0] P_SYM  = 7'h01;
  logic             clk;
  logic             rstn;
  logic [1:0]       modSelect;
  logic [6:0]       ctl;
  logic             pktActive;
  logic             rssiBelowThr;
  logic             carrierSense;
  logic             txSymbol;
  logic [11:0]      ex;
  int               errTotal;
  int               samplesChecked;
  int               cycles;
  int               preCnt;
  int               termCnt;
  wire logic        spiCsn, spiSclk, spiMosi, spiMiso, spiMisoOe, misoLine;
  wire logic        clearChannel, txPreambleStart, rxTerminate;
  wire logic [1:0]  radioState;
  wire logic [11:0] freqOffset;
  wire logic [10:0] devWord;

  // Data out pin pulled high while the device leaves it
  assign misoLine = spiMisoOe ? spiMiso : 1'b1;

  rdsc_host_model host (.clk(clk), .spiMiso(misoLine), .spiCsn(spiCsn), .spiSclk(spiSclk),
    .spiMosi(spiMosi));

  rdsc_top uut (.clk(clk), .rstn(rstn), .spiCsn(spiCsn), .spiSclk(spiSclk), .spiMosi(spiMosi),
    .spiMiso(spiMiso), .spiMisoOe(spiMisoOe), .modSelect(modSelect), .cmdIdle(ctl[6]),
    .cmdRx(ctl[5]), .cmdTx(ctl[4]), .cmdFstx(ctl[3]), .pktRxDone(ctl[2]), .pktTxDone(ctl[1]),
    .pktActive(pktActive), .rssiBelowThr(rssiBelowThr), .carrierSense(carrierSense),
    .symTick(ctl[0]), .txSymbol(txSymbol), .radioState(radioState), .freqOffset(freqOffset),
    .devWord(devWord), .clearChannel(clearChannel), .txPreambleStart(txPreambleStart),
    .rxTerminate(rxTerminate));

  // Clock source
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Hang guard, preamble and termination pulse counts
  always @(posedge clk)
  begin
    cycles++;
    if (txPreambleStart === 1'b1)
      preCnt++;
    if (rxTerminate === 1'b1)
      termCnt++;
    if (cycles == 20000)
    begin
      errTotal++;
      stopTest();
    end
  end

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    host.xfer({2'h0, a}, d, q);
  endtask

  task automatic rdChk(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] q;
    host.xfer({2'h2, a}, 8'h00, q);
    `CHK("register", e, q)
  endtask

  // One-cycle control pulse, then let the outputs settle
  task automatic pulse(input logic [6:0] p);
    ctl <= p;
    @(posedge clk);
    ctl <= 7'h00;
    repeat (3) @(posedge clk);
  endtask

  task automatic stopTest();
    $display("Checks %0d mismatches %0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Test sequence
  initial
  begin
    rstn = 1'b0;
    modSelect = 2'h0;
    ctl = 7'h00;
    {pktActive, rssiBelowThr, carrierSense, txSymbol} = 4'h0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    rdChk(`RDSC_ADDR_FREQ_DEV, 8'h47);
    rdChk(`RDSC_ADDR_RX_TERM, 8'h07);
    rdChk(`RDSC_ADDR_PKT_END, 8'h30);
    `CHK("devWord", 11'h0F0, devWord)
    wr(6'h2A, 8'hFF);
    rdChk(6'h2A, 8'h00);
    wr(`RDSC_ADDR_FREQ_DEV, 8'hFF);
    rdChk(`RDSC_ADDR_FREQ_DEV, 8'h77);
    // Every exponent with the mantissa counting down
    for (int i = 0; i < 8; i++)
    begin
      wr(`RDSC_ADDR_FREQ_DEV, {1'b0, i[2:0], 1'b0, 3'h7 - i[2:0]});
      ex = (12'h008 + {9'h000, 3'h7 - i[2:0]}) << i[2:0];
      `CHK("devWord", ex, devWord)
    end
    // Each modulation while transmitting, word is 0x400
    pulse(P_TX);
    for (int j = 0; j < 4; j++)
    begin
      modSelect <= j[1:0];
      txSymbol <= j[0];
      repeat (3) @(posedge clk);
      ex = (j == 2) ? 12'h000 : (j[0] ? 12'h400 : 12'hC00);
      `CHK("freqOffset", ex, freqOffset)
      ex = (j == 2) ? 12'h000 : 12'h400;
      `CHK("devWord", ex, devWord)
    end
    modSelect <= 2'h0;
    // Every next state after a sent and a received packet
    for (int k = 0; k < 4; k++)
    begin
      wr(`RDSC_ADDR_PKT_END, {4'h3, k[1:0], k[1:0]});
      pulse(P_IDLE);
      pulse(P_TX);
      pulse(P_TXD);
      `CHK("radioState", k[1:0], radioState)
      pulse(P_IDLE);
      pulse(P_RX);
      pulse(P_RXD);
      `CHK("radioState", k[1:0], radioState)
    end
    `CHK("preamble pulses", 1, preCnt)
    // Synth ready by command, then on to transmit
    pulse(P_IDLE);
    pulse(P_FST);
    `CHK("radioState", 2'h1, radioState)
    pulse(P_TX);
    `CHK("radioState", 2'h2, radioState)
    // Every clear channel selector against every input pair
    for (int s = 0; s < 4; s++)
    begin
      wr(`RDSC_ADDR_PKT_END, {2'h0, s[1:0], 4'h0});
      for (int c = 0; c < 4; c++)
      begin
        {rssiBelowThr, pktActive} <= c[1:0];
        repeat (3) @(posedge clk);
        ex = ((!s[0] || c[1]) && (!s[1] || !c[0])) ? 12'h001 : 12'h000;
        `CHK("clearChannel", ex, clearChannel)
      end
    end
    {rssiBelowThr, pktActive} <= 2'h0;
    // Carrier sense drop ends receive only when enabled
    for (int t = 0; t < 2; t++)
    begin
      wr(`RDSC_ADDR_RX_TERM, {3'h7, t[0], 4'h7});
      pulse(P_IDLE);
      pulse(P_RX);
      carrierSense <= 1'b1;
      repeat (4) @(posedge clk);
      carrierSense <= 1'b0;
      repeat (4) @(posedge clk);
      ex = t ? 12'h000 : 12'h003;
      `CHK("radioState", ex, radioState)
    end
    rdChk(`RDSC_ADDR_RX_TERM, 8'h17);
    // OOK receive times out on the eighth silent symbol
    modSelect <= 2'h2;
    pulse(P_IDLE);
    pulse(P_RX);
    repeat (7) pulse(P_SYM);
    `CHK("radioState", 2'h3, radioState)
    pulse(P_SYM);
    `CHK("radioState", 2'h0, radioState)
    `CHK("termination pulses", 2, termCnt)
    stopTest();
  end
endmodule // radio_deviation_and_state_config_tb_top
`default_nettype wire
